/* File: verilog/usbep_port.v */
/*
 * Configuration, status, byte accounting and FIFO window of one
 * endpoint (1 to 7) of the USB device controller.
 * Assumes the protocol engine, the command decoder and the direct
 * access master all run on mclk; data words are held in a two-entry
 * buffer inside this block, which also keeps the counts.
 * Register port: master holds reg_rd or reg_wr until reg_ack, then
 * drops the request in the cycle after it sees reg_ack.
 */
`timescale 1ns/1ps
`default_nettype none

`include "usbep_map.vh"

module usbep_port (
    input wire mclk,
    input wire rst,
    // Processor register port
    input wire reg_rd,
    input wire reg_wr,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg reg_ack,
    // Decoded commands, one-cycle pulses
    input wire endpoint_reinit_command,
    input wire endpoint_halt_command,
    input wire endpoint_invalid_command,
    input wire endpoint_disable_command,
    input wire endpoint_enable_command,
    input wire sw_pkt_end,
    // Protocol engine events, one-cycle pulses
    input wire token_in,
    input wire pkt_ok,
    input wire [1:0] pkt_pid,
    input wire rx_pkt_err,
    input wire tx_timeout,
    output reg token_nak,
    output reg token_stall,
    // OUT data from the link
    input wire rx_valid,
    input wire [15:0] rx_data,
    input wire rx_last,
    output wire rx_ready,
    // IN data to the link
    output wire tx_valid,
    output wire [15:0] tx_data,
    input wire tx_ready,
    // Direct access path
    input wire dma_wr_valid,
    input wire [15:0] dma_wr_data,
    input wire dma_wr_last,
    output wire dma_wr_ready,
    output wire dma_rd_valid,
    output wire [15:0] dma_rd_data,
    input wire dma_rd_ready,
    // Configuration and status seen by the controller
    output reg ep_dual_q,
    output reg ep_direct_q,
    output reg ep_dir_q,
    output reg [1:0] ep_type_q,
    output reg [1:0] iso_transactions_per_frame,
    output reg fifo_has_data_q
);
    reg [1:0] toggle_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg disable_q;
    reg [10:0] fill_q;
    reg [10:0] fill_d;
    reg [10:0] pkt0_q;
    reg [10:0] pkt0_d;
    reg [10:0] pkt1_q;
    reg [10:0] pkt1_d;
    reg [1:0] num_q;
    reg [1:0] num_d;
    reg [1:0] limit;
    reg buf_in_valid;
    reg [15:0] buf_in_data;
    reg prod_last;
    reg buf_out_ready;
    reg [31:0] rdata_d;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [15:0] buf_out_data;
    wire room;
    wire push;
    wire pop;
    wire commit;
    wire take;
    wire sel_cfg;
    wire sel_cnt;
    wire sel_win;
    wire cpu_path;
    wire win_wr_ok;
    wire win_rd_ok;
    wire win_wr_go;
    wire win_rd_go;
    wire hold;

    // A request seen while reg_ack is high is the tail of the last one
    assign take = (reg_rd | reg_wr) & ~reg_ack;
    assign sel_cfg = (reg_addr == `USBEP_OFS_CFG_STATUS);
    assign sel_cnt = (reg_addr == `USBEP_OFS_BYTE_COUNT);
    assign sel_win = (reg_addr == `USBEP_OFS_FIFO_WINDOW);
    assign cpu_path = ~ep_direct_q;
    assign win_wr_ok = take & reg_wr & sel_win & cpu_path & ep_dir_q;
    assign win_rd_ok = take & reg_rd & sel_win & cpu_path & ~ep_dir_q;

    always @* begin
        limit = ep_dual_q ? 2'h2 : 2'h1;
    end
    assign room = (num_q < limit);

    // Producer and consumer follow the direction; the unused side stays
    // idle so a wrong-way master cannot corrupt the counts.
    always @* begin
        buf_in_valid = 1'b0;
        buf_in_data = 16'h0000;
        prod_last = 1'b0;
        buf_out_ready = 1'b0;
        if (ep_dir_q) begin
            if (ep_direct_q) begin
                buf_in_valid = dma_wr_valid & room;
                buf_in_data = dma_wr_data;
                prod_last = dma_wr_last;
            end else begin
                buf_in_valid = win_wr_ok & room;
                buf_in_data = reg_wdata[15:0];
                prod_last = 1'b0;
            end
            buf_out_ready = tx_ready;
        end else begin
            buf_in_valid = rx_valid & room;
            buf_in_data = rx_data;
            prod_last = rx_last;
            buf_out_ready = ep_direct_q ? dma_rd_ready : win_rd_ok;
        end
    end

    usbep_buf2 u_buf (
        .mclk(mclk),
        .rst(rst),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    assign push = buf_in_valid & buf_in_ready;
    assign pop = buf_out_valid & buf_out_ready;
    assign win_wr_go = win_wr_ok & room & buf_in_ready;
    assign win_rd_go = win_rd_ok & buf_out_valid;
    // Window access on the register path waits for space or data
    assign hold = (win_wr_ok & ~win_wr_go) | (win_rd_ok & ~win_rd_go);

    // Back-pressure reaches each source only on its own path
    assign rx_ready = ~ep_dir_q & room & buf_in_ready;
    assign dma_wr_ready = ep_dir_q & ep_direct_q & room & buf_in_ready;
    assign tx_valid = ep_dir_q & buf_out_valid;
    assign tx_data = buf_out_data;
    assign dma_rd_valid = ~ep_dir_q & ep_direct_q & buf_out_valid;
    assign dma_rd_data = buf_out_data;

    // Packet-end command from the decoder closes a packet filled from the window
    assign commit = (push & prod_last) |
                    (sw_pkt_end & ep_dir_q & cpu_path & room);

    // Byte accounting: fill counts the open packet, pkt0/pkt1 the
    // closed ones in order of access.
    always @* begin
        fill_d = fill_q;
        pkt0_d = pkt0_q;
        pkt1_d = pkt1_q;
        num_d = num_q;
        if (push) begin
            fill_d = fill_d + `USBEP_BYTES_PER_WORD;
        end
        if (pop) begin
            if (num_q != 2'h0) begin
                if (pkt0_q <= `USBEP_BYTES_PER_WORD) begin
                    pkt0_d = pkt1_q;
                    pkt1_d = 11'h000;
                    num_d = num_q - 2'h1;
                end else begin
                    pkt0_d = pkt0_q - `USBEP_BYTES_PER_WORD;
                end
            end else if (fill_d >= `USBEP_BYTES_PER_WORD) begin
                fill_d = fill_d - `USBEP_BYTES_PER_WORD;
            end else begin
                fill_d = 11'h000;
            end
        end
        if (commit) begin
            if (num_d == 2'h0) begin
                pkt0_d = fill_d;
            end else begin
                pkt1_d = fill_d;
            end
            num_d = num_d + 2'h1;
            fill_d = 11'h000;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            fill_q <= 11'h000;
            pkt0_q <= 11'h000;
            pkt1_q <= 11'h000;
            num_q <= 2'h0;
            fifo_has_data_q <= 1'b0;
        end else begin
            fill_q <= fill_d;
            pkt0_q <= pkt0_d;
            pkt1_q <= pkt1_d;
            num_q <= num_d;
            fifo_has_data_q <= (num_d != 2'h0);
        end
    end

    // Endpoint state; hardware error outranks a software reinit
    always @* begin
        state_d = state_q;
        if (endpoint_reinit_command) begin
            state_d = `USBEP_ST_READY;
        end
        if ((rx_pkt_err | tx_timeout) &&
            (state_q != `USBEP_ST_STALL) &&
            (state_q != `USBEP_ST_INVALID)) begin
            state_d = `USBEP_ST_ERROR;
        end
        if (endpoint_halt_command) begin
            state_d = `USBEP_ST_STALL;
        end
        if (endpoint_invalid_command) begin
            state_d = `USBEP_ST_INVALID;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            state_q <= `USBEP_ST_READY;
            toggle_q <= `USBEP_TOG_DATA0;
            disable_q <= 1'b0;
            token_nak <= 1'b0;
            token_stall <= 1'b0;
        end else begin
            state_q <= state_d;
            if (endpoint_reinit_command) begin
                toggle_q <= `USBEP_TOG_DATA0;
            end else if (pkt_ok) begin
                // Isochronous PIDs come from the engine, others alternate
                if (ep_type_q == `USBEP_TT_ISO) begin
                    toggle_q <= pkt_pid;
                end else if (toggle_q == `USBEP_TOG_DATA0) begin
                    toggle_q <= `USBEP_TOG_DATA1;
                end else begin
                    toggle_q <= `USBEP_TOG_DATA0;
                end
            end
            // Disable wins over a same-cycle enable
            if (endpoint_disable_command) begin
                disable_q <= 1'b1;
            end else if (endpoint_enable_command) begin
                disable_q <= 1'b0;
            end
            token_nak <= token_in & disable_q;
            token_stall <= token_in & ~disable_q &
                           (state_q == `USBEP_ST_STALL);
        end
    end

    // Configuration fields; only the writable bits are stored
    always @(posedge mclk) begin
        if (rst) begin
            ep_dual_q <= 1'b0;
            ep_direct_q <= 1'b0;
            ep_dir_q <= 1'b0;
            ep_type_q <= `USBEP_TT_CONTROL;
            iso_transactions_per_frame <= 2'h0;
        end else if (take && reg_wr && sel_cfg) begin
            ep_dual_q <= reg_wdata[`USBEP_BIT_PKT_MODE];
            ep_direct_q <= reg_wdata[`USBEP_BIT_BUS_SEL];
            ep_dir_q <= reg_wdata[`USBEP_BIT_DIR];
            ep_type_q <= reg_wdata[`USBEP_TYPE_HI:`USBEP_TYPE_LO];
            iso_transactions_per_frame <=
                reg_wdata[`USBEP_NMF_HI:`USBEP_NMF_LO];
        end
    end

    // Read data; reserved and unmapped bits read zero
    always @* begin
        rdata_d = 32'h0000_0000;
        if (sel_cfg) begin
            rdata_d[`USBEP_BIT_PKT_MODE] = ep_dual_q;
            rdata_d[`USBEP_BIT_BUS_SEL] = ep_direct_q;
            rdata_d[`USBEP_TOG_HI:`USBEP_TOG_LO] = toggle_q;
            rdata_d[`USBEP_STATE_HI:`USBEP_STATE_LO] = state_q;
            rdata_d[`USBEP_BIT_DISABLE] = disable_q;
            rdata_d[`USBEP_BIT_DIR] = ep_dir_q;
            rdata_d[`USBEP_TYPE_HI:`USBEP_TYPE_LO] = ep_type_q;
            rdata_d[`USBEP_NMF_HI:`USBEP_NMF_LO] =
                iso_transactions_per_frame;
        end else if (sel_cnt) begin
            if (num_q != 2'h0) begin
                rdata_d[10:0] = pkt0_q;
            end else begin
                rdata_d[10:0] = fill_q;
            end
        end else if (sel_win && win_rd_go) begin
            rdata_d[15:0] = buf_out_data;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= `USBEP_RST_FIFO_WINDOW;
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= take & ~hold;
            if (take && reg_rd && !hold) begin
                reg_rdata <= rdata_d;
            end
        end
    end
endmodule

`default_nettype wire

/* File: verilog/usbep_map.vh */
/*
 * Register offsets, field positions, codes and reset values of the
 * per-endpoint status and FIFO port.
 * Assumes a word-aligned processor register port with a 4-bit offset.
 */
`ifndef USBEP_MAP_VH
`define USBEP_MAP_VH

// Register offsets on the processor register port
`define USBEP_OFS_CFG_STATUS 4'h0
`define USBEP_OFS_BYTE_COUNT 4'h4
`define USBEP_OFS_FIFO_WINDOW 4'h8

// Reset values
`define USBEP_RST_CFG_STATUS 32'h0000_0000
`define USBEP_RST_BYTE_COUNT 32'h0000_0000
`define USBEP_RST_FIFO_WINDOW 32'h0000_0000

// Field positions in endpoint_config_status
`define USBEP_BIT_PKT_MODE 15
`define USBEP_BIT_BUS_SEL 14
`define USBEP_TOG_HI 13
`define USBEP_TOG_LO 12
`define USBEP_STATE_HI 11
`define USBEP_STATE_LO 9
`define USBEP_BIT_DISABLE 8
`define USBEP_BIT_DIR 7
`define USBEP_TYPE_HI 3
`define USBEP_TYPE_LO 2
`define USBEP_NMF_HI 1
`define USBEP_NMF_LO 0

// Field width of the byte count and the FIFO data window, bytes per window word
`define USBEP_CNT_W 11
`define USBEP_DATA_W 16
`define USBEP_BYTES_PER_WORD 11'h002

// Data toggle codes
`define USBEP_TOG_DATA0 2'h0
`define USBEP_TOG_DATA1 2'h1
`define USBEP_TOG_DATA2 2'h2
`define USBEP_TOG_MDATA 2'h3

// Endpoint state codes
`define USBEP_ST_READY 3'h0
`define USBEP_ST_ERROR 3'h2
`define USBEP_ST_STALL 3'h3
`define USBEP_ST_INVALID 3'h7

// Transfer type codes
`define USBEP_TT_CONTROL 2'h0
`define USBEP_TT_ISO 2'h1
`define USBEP_TT_BULK 2'h2
`define USBEP_TT_INTR 2'h3

`endif

/* File: verilog/usbep_buf2.v */
/*
 * Two-entry valid/ready buffer in the endpoint data path.
 * Assumes both sides on the same clock; in_ready and out_valid come
 * from the occupancy register, so neither side sees a loop.
 */
`timescale 1ns/1ps
`default_nettype none

module usbep_buf2 (
    input wire mclk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [15:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [15:0] out_data
);
    reg [1:0] count_q;
    reg wr_ptr_q;
    reg rd_ptr_q;
    reg [15:0] mem_q [0:1];
    wire push;
    wire pop;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_entry
            always @(posedge mclk) begin
                if (rst) begin
                    mem_q[gi] <= 16'h0000;
                end else if (push && (wr_ptr_q == gi)) begin
                    mem_q[gi] <= in_data;
                end
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (rst) begin
            count_q <= 2'h0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: verification/usbep_port_sva.sv */
/* Pin-level assertions and covers for usbep_port.
   Assumes one clock mclk and a synchronous active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module usbep_port_sva (
    input wire mclk,
    input wire rst,
    input wire reg_rd,
    input wire reg_wr,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire reg_ack,
    input wire token_in,
    input wire token_nak,
    input wire token_stall,
    input wire tx_valid,
    input wire rx_ready,
    input wire dma_rd_valid,
    input wire ep_dual_q,
    input wire ep_direct_q,
    input wire ep_dir_q,
    input wire [1:0] ep_type_q
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // A request is taken only while no ack is showing
    wire cfg_wr = reg_wr && !reg_ack && reg_addr == 4'h0;
    wire rd_ack = reg_ack && reg_rd;
    AST_ACK_ONE: assert property (reg_ack |=> !reg_ack)
        else $error("ack held past one cycle");
    AST_CFG_MODE: assert property (cfg_wr |=> reg_ack &&
        ep_dual_q == $past(reg_wdata[15]) &&
        ep_direct_q == $past(reg_wdata[14]))
        else $error("mode bits not taken from write");
    AST_CFG_DIR: assert property (cfg_wr |=>
        ep_dir_q == $past(reg_wdata[7]) && ep_type_q == $past(reg_wdata[3:2]))
        else $error("direction or type not taken from write");
    AST_RD_ACK: assert property (reg_rd && !reg_ack &&
        reg_addr != 4'h8 |=> reg_ack)
        else $error("register read not answered next cycle");
    AST_WIN_HI: assert property (rd_ack && reg_addr == 4'h8 |->
        reg_rdata[31:16] == 16'h0000)
        else $error("window upper half not zero");
    AST_CNT_HI: assert property (rd_ack && reg_addr == 4'h4 |->
        reg_rdata[31:11] == 21'h00_0000)
        else $error("byte count unused bits not zero");
    AST_CFG_ZERO: assert property (rd_ack && reg_addr == 4'h0 |->
        reg_rdata[31:16] == 16'h0000 && reg_rdata[6:4] == 3'h0)
        else $error("status unused bits not zero");
    AST_TOKEN: assert property ((token_nak || token_stall) |->
        $past(token_in) && !(token_nak && token_stall))
        else $error("token answer without token or doubled");
    AST_TX_DIR: assert property (tx_valid |-> ep_dir_q)
        else $error("send data offered on an OUT endpoint");
    AST_RX_DIR: assert property (rx_ready |-> !ep_dir_q)
        else $error("receive ready on an IN endpoint");
    AST_DMA_PATH: assert property (dma_rd_valid |->
        ep_direct_q && !ep_dir_q)
        else $error("direct path offered data off its mode");
    CV_WIN_READ: cover property (rd_ack && reg_addr == 4'h8);
    CV_STALL: cover property (token_stall);
    CV_NAK: cover property (token_nak);
endmodule
bind usbep_port usbep_port_sva i_sva (.mclk, .rst, .reg_rd, .reg_wr,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .token_in, .token_nak,
    .token_stall, .tx_valid, .rx_ready, .dma_rd_valid, .ep_dual_q,
    .ep_direct_q, .ep_dir_q, .ep_type_q);
`default_nettype wire

/* File: verification/usbep_host.sv */
/* Host-side model: sends one-word OUT packets, takes IN words.
   Assumes the bench raises go for one cycle per packet. */
`timescale 1ns/1ps
`default_nettype none
module usbep_host (
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    input wire logic [15:0] base,
    input wire logic hold,
    input wire logic rx_ready,
    output logic rx_valid = 1'b0,
    output logic [15:0] rx_data = 16'h0000,
    output logic rx_last = 1'b0,
    output logic tx_ready = 1'b0,
    output logic busy = 1'b0
);
    always @(posedge mclk) begin
        // Random stalls so the buffer fills and refuses
        tx_ready <= !hold && ($urandom() % 3 != 0);
        if (rst) begin
            rx_valid <= 1'b0;
            busy <= 1'b0;
        end else if (go && !busy) begin
            rx_valid <= 1'b1;
            busy <= 1'b1;
            rx_data <= base;
            rx_last <= 1'b1;
        end else if (rx_valid && rx_ready) begin
            rx_valid <= 1'b0;
            busy <= 1'b0;
        end
        // Idle lines keep moving so stale data never matches
        if (!rst && !rx_valid && !(go && !busy)) begin
            rx_data <= ~rx_data;
            rx_last <= ~rx_last;
        end
    end
endmodule
`default_nettype wire

/* File: verification/usbep_port_test.sv */
/* Self-checking bench of usbep_port against a host model.
   Assumes the register map header and usbep_host. */
`timescale 1ns/1ps
`default_nettype none
`include "usbep_map.vh"
module usbep_port_test;
    localparam logic [31:0] Z = 32'h0000_0000;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = Z;
    logic [9:0] ev = 10'h000;
    logic [1:0] pkt_pid = 2'h0;
    logic go = 1'b0;
    logic hold = 1'b1;
    logic [15:0] base = 16'h0000;
    wire [31:0] reg_rdata;
    wire [15:0] rx_data, tx_data;
    wire [1:0] ep_type_q, iso_transactions_per_frame;
    wire reg_ack, token_nak, token_stall, rx_valid, rx_last, rx_ready;
    wire tx_valid, tx_ready, dma_rd_valid, busy, fifo_has_data_q;
    wire dw_r;
    wire [15:0] dma_rd_data;
    logic dw_v = 1'b0;
    logic dw_l = 1'b0;
    logic [15:0] dw_d = 16'h0000;
    logic [15:0] dq;
    wire ep_dual_q, ep_direct_q, ep_dir_q;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] q, d, cfg;
    logic nak_s, stall_s;
    logic [15:0] b[2];
    logic [31:0] w[2];
    logic [15:0] txq[$];
    // Command mask, state, disable, nak, stall
    logic [15:0] tbl[18] = '{16'h0098, 16'h4018, 16'h8018, 16'h0040,
        16'h4050, 16'h0040, 16'h8010, 16'h0138, 16'h4038, 16'h0040,
        16'h1000, 16'h0098, 16'h1019, 16'h0040, 16'h0204, 16'h1006,
        16'h0604, 16'h0400};

    usbep_port i_dut (.mclk, .rst, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_ack, .endpoint_reinit_command(ev[0]),
        .endpoint_halt_command(ev[1]), .endpoint_invalid_command(ev[2]),
        .endpoint_disable_command(ev[3]), .endpoint_enable_command(ev[4]),
        .sw_pkt_end(ev[5]), .token_in(ev[6]), .pkt_ok(ev[7]), .pkt_pid,
        .rx_pkt_err(ev[8]), .tx_timeout(ev[9]), .token_nak, .token_stall,
        .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data,
        .tx_ready, .dma_wr_valid(dw_v), .dma_wr_data(dw_d),
        .dma_wr_last(dw_l), .dma_wr_ready(dw_r), .dma_rd_valid,
        .dma_rd_data, .dma_rd_ready(1'b1), .ep_dual_q, .ep_direct_q,
        .ep_dir_q, .ep_type_q, .iso_transactions_per_frame,
        .fifo_has_data_q);
    usbep_host i_host (.mclk, .rst, .go, .base, .hold, .rx_ready,
        .rx_valid, .rx_data, .rx_last, .tx_ready, .busy);

    always #4 mclk = ~mclk;
    always @(posedge mclk)
        if (tx_valid && tx_ready)
            txq.push_back(tx_data);
    always @(posedge mclk)
        if (dma_rd_valid)
            dq <= dma_rd_data;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    function automatic logic [31:0] cfg_of(input logic [31:0] v);
        return v & 32'h0000_C08F;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rw(input logic wr, input logic [3:0] a,
        input logic [31:0] v);
        int n;
        n = 0;
        reg_addr <= a;
        reg_wdata <= v;
        reg_rd <= !wr;
        reg_wr <= wr;
        @(posedge mclk);
        while (reg_ack !== 1'b1 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        q = reg_rdata;
        chk("reg ack", 32'h1, {31'h0, reg_ack});
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pulse(input logic [9:0] m);
        ev <= m;
        @(posedge mclk);
        ev <= 10'h000;
        @(posedge mclk);
        nak_s = token_nak;
        stall_s = token_stall;
    endtask
    task automatic setcfg(input logic [31:0] v);
        rw(1'b1, 4'h0, v);
        cfg = cfg_of(v);
    endtask
    task automatic sts(input logic [1:0] tg, input logic [2:0] st,
        input logic ds);
        rw(1'b0, 4'h0, Z);
        chk("status", cfg | {18'h0_0000, tg, st, ds, 8'h00}, q);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        void'($urandom(96));
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        cfg = Z;
        sts(`USBEP_TOG_DATA0, `USBEP_ST_READY, 1'b0);
        rw(1'b1, 4'h4, 32'hFFFF_FFFF);
        rw(1'b0, 4'h4, Z);
        chk("count", Z, q);
        rw(1'b0, 4'hC, Z);
        chk("unmapped", Z, q);
        $display("test reset done");
        for (int t = 0; t < 4; t++) begin
            for (int n = 0; n < 3; n++) begin
                d = ($urandom() & 32'hFFFF_FF70) | 32'h0000_0080;
                d = d | 32'(t << 2) | 32'(n);
                setcfg(d);
                sts(2'h0, 3'h0, 1'b0);
                chk("type", 32'(t), {30'h0, ep_type_q});
                q = {30'h0, iso_transactions_per_frame};
                chk("iso", 32'(n), q);
                q = {29'h0, ep_dual_q, ep_direct_q, ep_dir_q};
                chk("mirror", {29'h0, d[15:14], d[7]}, q);
            end
        end
        $display("test config done");
        foreach (tbl[i]) begin
            pulse(tbl[i][15:6]);
            chk("nak", {31'h0, tbl[i][1]}, {31'h0, nak_s});
            chk("stall", {31'h0, tbl[i][0]}, {31'h0, stall_s});
            sts(2'h0, tbl[i][5:3], tbl[i][2]);
        end
        setcfg(32'h0000_0088);
        pulse(10'h080);
        sts(`USBEP_TOG_DATA1, 3'h0, 1'b0);
        pulse(10'h080);
        sts(`USBEP_TOG_DATA0, 3'h0, 1'b0);
        setcfg(32'h0000_0084);
        for (int p = 1; p < 4; p++) begin
            pkt_pid <= 2'(p);
            pulse(10'h080);
            sts(2'(p), 3'h0, 1'b0);
        end
        pulse(10'h001);
        sts(`USBEP_TOG_DATA0, 3'h0, 1'b0);
        $display("test state done");
        for (int m = 0; m < 3; m++) begin
            setcfg({16'h0000, m == 1, m == 2, 14'h0008});
            for (int k = 0; k <= 32'(m == 1); k++) begin
                b[k] = 16'($urandom());
                base <= b[k];
                go <= 1'b1;
                @(posedge mclk);
                go <= 1'b0;
                @(posedge mclk);
                for (int n = 0; n < 100 && busy !== 1'b0; n++)
                    @(posedge mclk);
                q = {31'h0, rx_ready};
                if (m < 2)
                    chk("rx ready", {31'h0, m == 1 && k == 0}, q);
            end
            if (m < 2) begin
                rw(1'b0, 4'h4, Z);
                chk("count", 32'h0000_0002, q);
                chk("has data", 32'h1, {31'h0, fifo_has_data_q});
                for (int k = 0; k <= m; k++) begin
                    rw(1'b0, 4'h8, Z);
                    chk("window", {16'h0000, b[k]}, q);
                end
            end
            rw(1'b0, 4'h4, Z);
            chk("count empty", Z, q);
            chk("has data", Z, {31'h0, fifo_has_data_q});
            if (m == 2)
                chk("dma word", {16'h0000, b[0]}, {16'h0000, dq});
        end
        $display("test receive done");
        setcfg(32'h0000_0088);
        hold <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            w[i] = $urandom();
            rw(1'b1, 4'h8, w[i]);
        end
        rw(1'b0, 4'h4, Z);
        chk("count open", 32'h0000_0004, q);
        pulse(10'h020);
        hold <= 1'b0;
        for (int n = 0; n < 200 && txq.size() < 2; n++)
            @(posedge mclk);
        for (int i = 0; i < 2; i++) begin
            q = {16'h0000, txq[i]};
            chk("tx word", {16'h0000, w[i][15:0]}, q);
        end
        setcfg(32'h0000_4088);
        chk("dma ready", 32'h1, {31'h0, dw_r});
        dw_d <= w[0][31:16];
        dw_l <= 1'b1;
        dw_v <= 1'b1;
        @(posedge mclk);
        for (int n = 0; n < 100 && dw_r !== 1'b1; n++)
            @(posedge mclk);
        dw_v <= 1'b0;
        for (int n = 0; n < 200 && txq.size() < 3; n++)
            @(posedge mclk);
        q = {16'h0000, txq[2]};
        chk("dma to tx", {16'h0000, w[0][31:16]}, q);
        $display("test send done");
        end_of_test();
    end
endmodule
`default_nettype wire
